// >>> card_interface_mode_select_tb_top.sv
/* self-checking bench for cims_card_if with a host model.
   assumes the checker is bound by its own file. */
`timescale 1ns/10ps
`default_nettype none

module card_interface_mode_select_tb_top;
   import cims_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   cims_bus_in_t bus_i;
   cims_bus_out_t bus_o;
   logic cm_rd, cm_wr, io_rd, io_wr, seen = 1'b0, cis_wr = 1'b0;
   logic [24:0] cm_word_addr;
   logic [1:0] cm_be, io_be;
   logic [15:0] cm_wdata, io_wdata, cm_rdata, io_rdata;
   logic [2:0] io_port;
   logic [7:0] cis_addr = 8'h00, cis_data = 8'h00;
   logic [7:0] cis_b[4];
   logic [6:0] st = 7'h00;
   logic [33:0] e;
   logic [33:0] rq[$];
   logic [40:0] wq[$];
   cims_mode_t mode;
   int bad_count = 0, cmp_count = 0, cyc = 0;

   // ****************
   // clock, far-side memories, instances
   // ****************
   always #2 ref_clk = ~ref_clk;
   assign cm_rdata = cm_word_addr[15:0] ^ 16'ha5c3;
   assign io_rdata = {5'h0, io_port, 8'h5a};

   cims_card_if dut (.ref_clk(ref_clk), .rst(rst), .bus_i(bus_i), .bus_o(bus_o), .cm_rd(cm_rd),
      .cm_wr(cm_wr), .cm_word_addr(cm_word_addr), .cm_be(cm_be), .cm_wdata(cm_wdata),
      .cm_rdata(cm_rdata), .cis_wr(cis_wr), .cis_addr(cis_addr), .cis_data(cis_data),
      .io_rd(io_rd), .io_wr(io_wr), .io_port(io_port), .io_be(io_be), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .card_ready(st[0]), .write_protect(st[1]), .battery_ok1(st[2]),
      .battery_ok2(st[3]), .irq_req(st[4]), .status_change(st[5]), .audio_bit(st[6]),
      .mode(mode));
   cims_host_model host (.ref_clk(ref_clk), .bus_o(bus_o), .bus_i(bus_i));

   // ****************
   // tasks
   // ****************
   task automatic cmp(input logic [40:0] got, input logic [40:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   // note {wide flag, ack, mask, data} then read
   task automatic rd(input logic io, input logic reg_n, input logic [25:0] a,
         input logic [15:0] x, input logic [15:0] m);
      rq.push_back({io ? ~a[2] ^ 1'b1 : st[1], ~io, m, x});
      host.acc(io, 1'b0, reg_n, a, 16'h0);
   endtask : rd

   task automatic wr(input logic io, input logic reg_n, input logic [25:0] a,
         input logic [15:0] d, input logic hit);
      if (hit) wq.push_back(io ? {22'h0, a[2:0], d} : {a[25:1], d});
      host.acc(io, 1'b1, reg_n, a, d);
   endtask : wr

   // shared pins two cycles after the inputs settle; protect only in memory mode
   task automatic pins(input logic io_m);
      repeat (2) @(negedge ref_clk);
      cmp({bus_o.ready_busy_line, bus_o.battery_detect_one_status_changed_line, bus_o.battery_detect_two_audio, io_m | bus_o.wp_wide_n},
         io_m ? {~st[4], ~st[5], ~st[6], 1'b1} : {st[0], st[2], st[3], st[1]});
   endtask : pins

   // ****************
   // result watcher and timeout
   // ****************
   always @(posedge ref_clk) begin
      if (bus_o.data_oe && bus_o.wait_n && !seen) begin
         e = rq.size() > 0 ? rq.pop_front() : '1;
         cmp({bus_o.wp_wide_n, bus_o.input_port_ack_n, bus_o.data & e[31:16]}, {e[33:32], e[15:0]});
      end
      seen = bus_o.data_oe && (seen || bus_o.wait_n);
      if (cm_wr) cmp({cm_word_addr, cm_wdata}, wq.size() > 0 ? wq.pop_front() : '1);
      if (io_wr) cmp({22'h0, io_port, io_wdata}, wq.size() > 0 ? wq.pop_front() : '1);
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         conclude();
      end
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      int k;
      logic [25:0] a;
      logic [15:0] d;
      void'($urandom(61058));
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'b0;
      cmp(mode, CIMS_MODE_MEM);
      st = 7'($urandom);
      pins(1'b0);
      for (k = 0; k < 4; k++) begin
         @(negedge ref_clk);
         cis_wr = 1'b1;
         cis_addr = 8'(k);
         cis_data = 8'($urandom);
         cis_b[k] = cis_data;
      end
      @(negedge ref_clk) cis_wr = 1'b0;
      for (k = 0; k < 4; k++) rd(1'b0, 1'b0, 26'(2 * k), {8'h0, cis_b[k]}, 16'h00ff);
      rd(1'b0, 1'b0, 26'h1, 16'h0, 16'hff00);
      for (k = 0; k < 4; k++) begin
         a = k == 0 ? 26'h3fffffe : 26'($urandom) & 26'h3fffffe;
         d = 16'($urandom);
         wr(1'b0, 1'b1, a, d, 1'b1);
         rd(1'b0, 1'b1, a, a[16:1] ^ 16'ha5c3, 16'hffff);
      end
      host.acc(1'b1, 1'b0, 1'b0, 26'h0, 16'h0);
      host.acc(1'b1, 1'b1, 1'b0, 26'h1, 16'h77);
      wr(1'b0, 1'b0, CIMS_CFG_INDEX_ADDR, 16'h0001, 1'b0);
      cmp(mode, CIMS_MODE_IO);
      pins(1'b1);
      for (k = 0; k < 8; k++) rd(1'b1, 1'b0, {16'($urandom), 10'(k)}, {5'h0, 3'(k), 8'h5a}, 16'hffff);
      host.acc(1'b1, 1'b0, 1'b0, 26'h8, 16'h0);
      wr(1'b1, 1'b0, 26'h3fffc05, 16'($urandom), 1'b1);
      host.hold_rst(1'b1);
      host.acc(1'b0, 1'b0, 1'b1, 26'h10, 16'h0);
      host.acc(1'b0, 1'b1, 1'b1, 26'h10, 16'h1234);
      host.hold_rst(1'b0);
      cmp(mode, CIMS_MODE_MEM);
      wr(1'b0, 1'b0, CIMS_CFG_INDEX_ADDR, 16'h003f, 1'b0);
      cmp(mode, CIMS_MODE_CUSTOM);
      host.acc(1'b1, 1'b0, 1'b0, 26'h0, 16'h0);
      @(negedge ref_clk) rst = 1'b1;
      @(negedge ref_clk) rst = 1'b0;
      cmp(mode, CIMS_MODE_MEM);
      conclude();
   end
endmodule : card_interface_mode_select_tb_top

`default_nettype wire

// >>> cims_attr_mem.sv
/*
 * cims_attr_mem: byte-wide attribute store holding the card information
 * structure, one write port and a registered read port.
 * Assumes the loader and the reader share the card clock; contents are
 * not cleared by reset.
 */
`timescale 1ns/10ps
`default_nettype none

module cims_attr_mem
   import cims_pkg::*;
(
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [cims_pkg::CIMS_ATTR_AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [cims_pkg::CIMS_ATTR_AW-1:0] rd_addr,
   output logic [7:0] rd_data
);

   // ************************************************************
   // storage
   // ************************************************************
   logic [7:0] mem_r [0:(1<<CIMS_ATTR_AW)-1];

   // write then registered read; no reset so it maps to block ram
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
      rd_data <= mem_r[rd_addr];
   end

endmodule : cims_attr_mem

`default_nettype wire

// >>> cims_card_if.sv
/*
 * cims_card_if: card-side interface-mode selection, common and attribute
 * space decode, configuration registers, partial I/O decode and the
 * repurposed status pins.
 * Assumes host pins are synchronous to ref_clk and that the host keeps
 * address and data steady for the whole strobe.
 */
// Notes on behaviour
// [RULE_01] common space of 64 MB on a 26-bit address, readable and writable
// [RULE_02] separate attribute space chosen whenever register select is low
// [RULE_03] host never uses direct memory access on attribute space
// [RULE_04] information structure begins at attribute address zero, may be split
// [RULE_05] structure and configuration registers kept at low attribute addresses
// [RULE_06] memory-only interface after insertion, power-up and card reset
// [RULE_07] I/O mode repurposes ready, protect and battery pins, adds I/O signals
// [RULE_08] host shares one 64 MB I/O space among all cards
// [RULE_09] wide-port flag low only when address hits a 16-bit port
// [RULE_10] host may split 16-bit access to an 8-bit port in two
// [RULE_11] card decodes only up to address bit nine; host qualifies with bits 9/8
// [RULE_12] input port acknowledge low while one of our input ports is read
// [RULE_13] no I/O space nor I/O interface before configuration
// [RULE_14] host reads the structure first and may leave the card unconfigured
// [RULE_15] decode only enough lines for our ports, base placed by the host
// [RULE_16] bus-cycle extend and card reset work in every mode
// [RULE_17] 8-bit host holds odd-byte enable inactive
// [RULE_18] custom mode entered by writing the configuration index register
// [RULE_19] configuration registers sit in attribute space where advertised
// [RULE_20] socket picks memory-only when the slot is empty
// [RULE_21] even enable gates even bytes, odd enable gates odd bytes
// [RULE_22] host waits 20 ms after power or reset before enabling the card
// [RULE_23] no reads answered and no writes taken while card reset is high
// [RULE_24] memory-only mode ignores I/O strobes, wide flag and acknowledge negated
// [RULE_25] nonzero index selects I/O or custom; reset returns memory-only
`timescale 1ns/10ps
`default_nettype none

module cims_card_if (
   input wire logic ref_clk,
   input wire logic rst,
   input wire cims_pkg::cims_bus_in_t bus_i,
   output cims_pkg::cims_bus_out_t bus_o,
   // common memory array behind the card
   output logic cm_rd,
   output logic cm_wr,
   output logic [24:0] cm_word_addr,
   output logic [1:0] cm_be,
   output logic [15:0] cm_wdata,
   input wire logic [15:0] cm_rdata,
   // loader for the information structure
   input wire logic cis_wr,
   input wire logic [cims_pkg::CIMS_ATTR_AW-1:0] cis_addr,
   input wire logic [7:0] cis_data,
   // card function side
   output logic io_rd,
   output logic io_wr,
   output logic [cims_pkg::CIMS_IO_PORT_W-1:0] io_port,
   output logic [1:0] io_be,
   output logic [15:0] io_wdata,
   input wire logic [15:0] io_rdata,
   input wire logic card_ready,
   input wire logic write_protect,
   input wire logic battery_ok1,
   input wire logic battery_ok2,
   input wire logic irq_req,
   input wire logic status_change,
   input wire logic audio_bit,
   output cims_pkg::cims_mode_t mode
);
   import cims_pkg::*;

   // ************************************************************
   // helpers
   // ************************************************************
   // partial decode: bits above nine are never looked at
   function automatic logic io_hit(input logic [25:0] a, input logic [6:0] base);
      io_hit = (a[CIMS_IO_DEC_HI:CIMS_IO_PORT_W] == base);
   endfunction : io_hit

   // lane placement of read data for word, even byte and odd byte cycles
   function automatic logic [15:0] lane_out(input logic [15:0] w, input logic ce1_n,
                                            input logic ce2_n, input logic a0);
      if (!ce1_n && !ce2_n) begin
         lane_out = w;
      end else if (!ce1_n) begin
         lane_out = {8'h00, (a0 ? w[15:8] : w[7:0])};
      end else begin
         lane_out = {w[15:8], 8'h00};
      end
   endfunction : lane_out

   function automatic logic [1:0] lane_be(input logic ce1_n, input logic ce2_n,
                                          input logic a0);
      if (!ce1_n && !ce2_n) begin
         lane_be = 2'h3;
      end else if (!ce1_n) begin
         lane_be = a0 ? 2'h2 : 2'h1;
      end else if (!ce2_n) begin
         lane_be = 2'h2;
      end else begin
         lane_be = 2'h0;
      end
   endfunction : lane_be

   function automatic logic [15:0] lane_in(input logic [15:0] d, input logic ce1_n,
                                           input logic ce2_n);
      lane_in = (!ce1_n && ce2_n) ? {d[7:0], d[7:0]} : d;
   endfunction : lane_in

   // ************************************************************
   // state and attribute store
   // ************************************************************
   cims_state_t s_r;
   cims_state_t s_nxt;
   logic [7:0] attr_rdata;
   logic ce_any;
   logic mem_rd;
   logic mem_wr_edge;
   logic io_sel;
   logic io_rd_act;
   logic io_wr_edge;
   logic rd_start;
   logic [15:0] rd_word;

   cims_attr_mem u_attr (
      .ref_clk(ref_clk),
      .wr_en(cis_wr),
      .wr_addr(cis_addr),
      .wr_data(cis_data),
      .rd_addr(bus_i.addr[CIMS_ATTR_AW:1]),
      .rd_data(attr_rdata)
   );

   // ************************************************************
   // access decode
   // ************************************************************
   // reset masks every access; the socket may hold it for a long time
   assign ce_any = (!bus_i.ce1_n || !bus_i.ce2_n) && !bus_i.card_reset; // see [RULE_23]
   assign mem_rd = ce_any && !bus_i.oe_n;
   assign mem_wr_edge = ce_any && !bus_i.we_n && s_r.prev_we_n;
   // I/O exists only once configured, and register select doubles as I/O enable
   assign io_sel = (s_r.mode == CIMS_MODE_IO) && ce_any && !bus_i.reg_n
                   && io_hit(bus_i.addr, s_r.io_base);           // see [RULE_13] [RULE_15]
   assign io_rd_act = io_sel && !bus_i.io_read_strobe_n;                   // see [RULE_24]
   assign io_wr_edge = io_sel && !bus_i.io_write_strobe_n && s_r.prev_io_write_strobe_n;
   assign rd_start = (mem_rd && s_r.prev_oe_n) || (io_rd_act && s_r.prev_io_read_strobe_n);

   // common memory port: reads follow the strobe level, writes are one pulse
   assign cm_rd = mem_rd && bus_i.reg_n;                         // see [RULE_01]
   assign cm_wr = mem_wr_edge && bus_i.reg_n;
   assign cm_word_addr = bus_i.addr[25:1];
   assign cm_be = lane_be(bus_i.ce1_n, bus_i.ce2_n, bus_i.addr[0]); // see [RULE_21]
   assign cm_wdata = lane_in(bus_i.data, bus_i.ce1_n, bus_i.ce2_n);

   assign io_rd = io_rd_act;
   assign io_wr = io_wr_edge;
   assign io_port = bus_i.addr[CIMS_IO_PORT_W-1:0];
   assign io_be = cm_be;
   assign io_wdata = cm_wdata;
   assign mode = s_r.mode;

   // read word source: attribute holds bytes at even addresses only
   always_comb begin
      rd_word = 16'h0000;
      if (io_rd_act) begin
         rd_word = io_rdata;
      end else if (bus_i.reg_n) begin
         rd_word = cm_rdata;
      end else if (bus_i.addr == CIMS_CFG_INDEX_ADDR) begin // see [RULE_19]
         rd_word = {10'h000, s_r.cfg_index};
      end else if (bus_i.addr == CIMS_CFG_IOBASE_ADDR) begin
         rd_word = {9'h000, s_r.io_base};
      end else if (bus_i.addr[25:CIMS_ATTR_AW+1] == '0) begin
         // structure lives from address zero upward, low enough for any host
         rd_word = {8'h00, attr_rdata};                       // see [RULE_04] [RULE_05]
      end
   end

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.prev_we_n = bus_i.we_n;
      s_nxt.prev_io_write_strobe_n = bus_i.io_write_strobe_n;
      s_nxt.prev_oe_n = bus_i.oe_n;
      s_nxt.prev_io_read_strobe_n = bus_i.io_read_strobe_n;
      if (bus_i.card_reset) begin
         // card reset acts in every mode and drops back to memory-only
         s_nxt = CIMS_STATE_RST;                              // see [RULE_06] [RULE_16]
      end else begin
         // configuration writes land only in attribute space
         if (mem_wr_edge && !bus_i.reg_n && !bus_i.ce1_n) begin // see [RULE_02]
            if (bus_i.addr == CIMS_CFG_INDEX_ADDR) begin
               s_nxt.cfg_index = bus_i.data[5:0];
               case (bus_i.data[5:0])
                  CIMS_CFG_INDEX_RST: s_nxt.mode = CIMS_MODE_MEM;
                  CIMS_CUSTOM_INDEX: s_nxt.mode = CIMS_MODE_CUSTOM; // see [RULE_18]
                  default: s_nxt.mode = CIMS_MODE_IO;                // see [RULE_25]
               endcase
            end else if (bus_i.addr == CIMS_CFG_IOBASE_ADDR) begin
               s_nxt.io_base = bus_i.data[6:0];
            end
         end
         // extend the cycle while the read path settles
         if (rd_start) begin
            s_nxt.rd_cnt = CIMS_RD_WAIT_CYC;                  // see [RULE_16]
         end else if (s_r.rd_cnt != 2'h0) begin
            s_nxt.rd_cnt = s_r.rd_cnt - 2'h1;
         end
      end
      s_nxt.pins.wait_n = (s_nxt.rd_cnt == 2'h0);
      // data drivers only during an answered read
      s_nxt.pins.data_oe = (mem_rd && !(bus_i.reg_n == 1'b0 && !bus_i.io_read_strobe_n)) || io_rd_act;
      s_nxt.pins.data = s_nxt.pins.data_oe ?
                        lane_out(rd_word, bus_i.ce1_n, bus_i.ce2_n, bus_i.addr[0]) : 16'h0000;
      // shared pins change meaning with the selected interface
      case (s_nxt.mode)
         CIMS_MODE_IO: begin
            s_nxt.pins.ready_busy_line = !irq_req;                       // see [RULE_07]
            s_nxt.pins.wp_wide_n = !(io_sel && CIMS_IO_WIDE_MASK[io_port]); // see [RULE_09]
            s_nxt.pins.battery_detect_one_status_changed_line = !status_change;
            s_nxt.pins.battery_detect_two_audio = !audio_bit;
            s_nxt.pins.input_port_ack_n = !io_rd_act;                    // see [RULE_12]
         end
         CIMS_MODE_CUSTOM: begin
            // custom signals are not ours; ready follows card_ready, the other shared pins stay quiet
            s_nxt.pins.ready_busy_line = card_ready;
            s_nxt.pins.wp_wide_n = 1'b1;
            s_nxt.pins.battery_detect_one_status_changed_line = 1'b1;
            s_nxt.pins.battery_detect_two_audio = 1'b1;
            s_nxt.pins.input_port_ack_n = 1'b1;
         end
         default: begin
            s_nxt.pins.ready_busy_line = card_ready;
            s_nxt.pins.wp_wide_n = write_protect;
            s_nxt.pins.battery_detect_one_status_changed_line = battery_ok1;
            s_nxt.pins.battery_detect_two_audio = battery_ok2;
            s_nxt.pins.input_port_ack_n = 1'b1;                          // see [RULE_24]
         end
      endcase
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_r <= CIMS_STATE_RST;                               // see [RULE_06]
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus_o = s_r.pins;

endmodule : cims_card_if

`default_nettype wire

// >>> cims_card_if_asserts.sv
/* checker for the card-side mode and space logic, watching its ports.
   assumes one reset domain on ref_clk and a bind onto cims_card_if. */
`timescale 1ns/10ps
`default_nettype none

module cims_card_if_chk
   import cims_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire cims_pkg::cims_bus_in_t bus_i,
   input wire cims_pkg::cims_bus_out_t bus_o,
   input wire logic cm_rd,
   input wire logic cm_wr,
   input wire logic [24:0] cm_word_addr,
   input wire logic [1:0] cm_be,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic write_protect,
   input wire cims_pkg::cims_mode_t mode
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // card reset always lands in memory-only mode
   crst_mode_a: assert property (bus_i.card_reset |=> mode == CIMS_MODE_MEM)
      else $error("mode not memory-only after card reset");
   mem_quiet_a: assert property (mode == CIMS_MODE_MEM |-> bus_o.input_port_ack_n && !io_rd && !io_wr)
      else $error("io activity in memory-only mode");
   // guard on past reset: pins sampled right after release still hold reset values
   mem_pins_a: assert property (mode == CIMS_MODE_MEM && $past(mode) == CIMS_MODE_MEM && !$past(rst)
      && !$past(bus_i.card_reset) |-> bus_o.wp_wide_n == $past(write_protect))
      else $error("protect pin does not follow input");
   io_ack_a: assert property (mode == CIMS_MODE_IO && !bus_o.input_port_ack_n |-> !$past(bus_i.io_read_strobe_n))
      else $error("input acknowledge without io read");
   io_wide_a: assert property (mode == CIMS_MODE_IO && $past(mode) == CIMS_MODE_IO && !bus_o.wp_wide_n
      |-> $past(bus_i.addr[2:0]) < 3'h4)
      else $error("wide flag on a narrow port");
   crst_quiet_a: assert property (bus_i.card_reset |-> !cm_rd && !cm_wr && !io_rd && !io_wr ##1 !bus_o.data_oe)
      else $error("access served during card reset");
   cwr_pulse_a: assert property (cm_wr |-> bus_i.reg_n && !bus_i.we_n ##1 !cm_wr)
      else $error("common write not a single pulse");
   cm_addr_a: assert property (cm_rd |-> bus_i.reg_n && cm_word_addr == bus_i.addr[25:1])
      else $error("common read address or space wrong");
   byte_lane_a: assert property (cm_wr |-> cm_be == {!bus_i.ce2_n || (!bus_i.ce1_n && bus_i.addr[0]),
      !bus_i.ce1_n && (!bus_i.ce2_n || !bus_i.addr[0])})
      else $error("byte enables do not match card enables");
   io_mode_a: assert property (io_rd || io_wr |-> mode == CIMS_MODE_IO)
      else $error("io access before configuration");

   // main scenarios reached
   cov_ack: cover property (mode == CIMS_MODE_IO && !bus_o.input_port_ack_n);
   cov_cwr: cover property (cm_wr);
   cov_back: cover property ($past(mode) == CIMS_MODE_IO && mode == CIMS_MODE_MEM);
endmodule : cims_card_if_chk

bind cims_card_if cims_card_if_chk u_chk (.ref_clk(ref_clk), .rst(rst), .bus_i(bus_i),
   .bus_o(bus_o), .cm_rd(cm_rd), .cm_wr(cm_wr), .cm_word_addr(cm_word_addr), .cm_be(cm_be),
   .io_rd(io_rd), .io_wr(io_wr), .write_protect(write_protect), .mode(mode));

`default_nettype wire

// >>> cims_host_model.sv
/* host socket side: drives card pins one access at a time.
   assumes the bench calls its tasks in sequence, never two at once. */
`timescale 1ns/10ps
`default_nettype none

module cims_host_model
   import cims_pkg::*;
(
   input wire logic ref_clk,
   input wire cims_pkg::cims_bus_out_t bus_o,
   output var cims_pkg::cims_bus_in_t bus_i
);
   // idle: enables and strobes high, reset low
   initial begin
      bus_i = {26'h0, 16'h0, 7'h7f, 1'b0};
   end

   // one access; reads wait for settled data, refused ones give up after 8
   // plain host cycles only: no dma on attribute space, no 16-to-8 split
   // io addresses come from one shared space; slot always holds the card
   task automatic acc(input logic io, input logic wr, input logic reg_n,
         input logic [25:0] a, input logic [15:0] d);
      int i;
      @(negedge ref_clk);
      bus_i.addr = a;
      bus_i.data = d;
      bus_i.reg_n = reg_n;
      bus_i.ce1_n = 1'b0; // 16-bit host, both enables used
      bus_i.ce2_n = 1'b0;
      {bus_i.io_write_strobe_n, bus_i.io_read_strobe_n, bus_i.we_n, bus_i.oe_n} = ~(4'h1 << {io, wr});
      for (i = 0; i < 8; i++) begin
         @(negedge ref_clk);
         if (wr ? i == 1 : bus_o.data_oe && bus_o.wait_n) break;
      end
      // strobes rise between accesses; released lines must not keep old values
      {bus_i.io_write_strobe_n, bus_i.io_read_strobe_n, bus_i.we_n, bus_i.oe_n} = 4'hf;
      bus_i.ce1_n = 1'b1;
      bus_i.ce2_n = 1'b1;
      bus_i.reg_n = 1'b1;
      bus_i.addr = ~a;
      bus_i.data = ~d;
      @(negedge ref_clk);
   endtask : acc

   // callers leave idle cycles after reset before the next enable
   task automatic hold_rst(input logic v);
      @(negedge ref_clk);
      bus_i.card_reset = v;
   endtask : hold_rst
endmodule : cims_host_model

`default_nettype wire

// >>> cims_pkg.sv
/*
 * cims_pkg: constants, pin bundles and state record for the card-side
 * interface-mode and address-space logic.
 * Assumes a single clock domain; every card pin is already synchronous.
 */
`default_nettype none

package cims_pkg;

   // ************************************************************
   // widths and sizes
   // ************************************************************
   localparam int CIMS_ADDR_W = 26;           // 64 MB in every space
   localparam int CIMS_DATA_W = 16;
   localparam int CIMS_ATTR_AW = 8;           // address bits of the attribute bytes held on the card (256 bytes)
   localparam int CIMS_IO_PORT_W = 3;         // eight I/O ports
   localparam int CIMS_IO_DEC_HI = 9;         // partial decode reaches bit nine

   // ************************************************************
   // attribute map and configuration fields
   // ************************************************************
   localparam logic [25:0] CIMS_CIS_BASE = 26'h0000000;    // structure starts at zero
   localparam logic [25:0] CIMS_CFG_INDEX_ADDR = 26'h0000200;
   localparam logic [25:0] CIMS_CFG_IOBASE_ADDR = 26'h0000202;
   localparam logic [5:0] CIMS_CFG_INDEX_RST = 6'h00;
   localparam logic [5:0] CIMS_CUSTOM_INDEX = 6'h3f;       // index that picks the custom mode
   localparam logic [6:0] CIMS_IOBASE_RST = 7'h00;
   localparam logic [7:0] CIMS_IO_WIDE_MASK = 8'h0f;       // ports 0..3 are 16 bits wide

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CIMS_CLK_PERIOD_NS = 4;
   localparam int CIMS_RD_SETTLE_NS = 8;      // read data path settling
   localparam logic [1:0] CIMS_RD_WAIT_CYC =
      2'((CIMS_RD_SETTLE_NS + CIMS_CLK_PERIOD_NS - 1) / CIMS_CLK_PERIOD_NS);

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      CIMS_MODE_MEM,
      CIMS_MODE_IO,
      CIMS_MODE_CUSTOM
   } cims_mode_t;

   // host-driven card pins, active-low ones marked _n
   typedef struct packed {
      logic [25:0] addr;
      logic [15:0] data;
      logic ce1_n;            // even_byte_enable
      logic ce2_n;            // odd_byte_enable
      logic oe_n;
      logic we_n;
      logic reg_n;
      logic io_read_strobe_n;           // io_read_strobe
      logic io_write_strobe_n;           // io_write_strobe
      logic card_reset;
   } cims_bus_in_t;

   // card-driven pins; the four shared pins change meaning with the mode
   typedef struct packed {
      logic [15:0] data;
      logic data_oe;
      logic wait_n;
      logic ready_busy_line;       // mem: ready high; io: interrupt_request_line_n
      logic wp_wide_n;             // mem: write protect; io: io_port_wide_flag_n
      logic battery_detect_one_status_changed_line;           // mem: battery_detect_one; io: status_changed_line_n
      logic battery_detect_two_audio;            // mem: battery_detect_two; io: audio_wave_out_n
      logic input_port_ack_n;
   } cims_bus_out_t;

   typedef struct packed {
      cims_mode_t mode;
      logic [5:0] cfg_index;
      logic [6:0] io_base;
      logic prev_we_n;
      logic prev_io_write_strobe_n;
      logic prev_oe_n;
      logic prev_io_read_strobe_n;
      logic [1:0] rd_cnt;
      cims_bus_out_t pins;
   } cims_state_t;

   localparam cims_bus_out_t CIMS_PINS_RST = '{
      data: 16'h0000, data_oe: 1'b0, wait_n: 1'b1, ready_busy_line: 1'b0,
      wp_wide_n: 1'b0, battery_detect_one_status_changed_line: 1'b0, battery_detect_two_audio: 1'b0, input_port_ack_n: 1'b1};

   localparam cims_state_t CIMS_STATE_RST = '{
      mode: CIMS_MODE_MEM, cfg_index: CIMS_CFG_INDEX_RST, io_base: CIMS_IOBASE_RST,
      prev_we_n: 1'b1, prev_io_write_strobe_n: 1'b1, prev_oe_n: 1'b1, prev_io_read_strobe_n: 1'b1,
      rd_cnt: 2'h0, pins: CIMS_PINS_RST};

endpackage : cims_pkg

`default_nettype wire
